// *** hw/ulr_link_end.sv ***
// Link end: AXI4-Lite controlled register reads and status capture
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module ulr_link_end
    import ulr_pkg::*;
(
    // Clock and reset
    input  logic        sys_clk,
    input  logic        sys_rst,
    input  logic        clkEn,
    // Shared bus
    ulr_bus_if.link     bus,
    // AXI4-Lite slave
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready
);

    typedef enum logic [5:0] {
        L_IDLE = 6'h01,
        L_CMD  = 6'h02,
        L_EXT  = 6'h04,
        L_WAIT = 6'h08,
        L_TURN = 6'h10,
        L_GAP  = 6'h20
    } ulr_link_state_t;

    ulr_link_state_t state_r;
    logic [7:0]      reqAddr_r;
    logic            reqExt_r;
    logic            busy_r;
    logic            done_r;
    logic [7:0]      rdByte_r;
    logic [7:0]      rxByte_r;
    logic            rxNew_r;
    logic            stp_r;
    logic [7:0]      dataOut_r;
    logic            oeN_r;
    logic            dirPrev_r;
    logic            awHeld_r;
    logic [7:0]      awAddr_r;
    logic            wHeld_r;
    logic [31:0]     wData_r;
    logic [3:0]      wStrb_r;
    logic            bvalid_r;
    logic [1:0]      bresp_r;
    logic            rvalid_r;
    logic [31:0]     rdata_r;
    logic [1:0]      rresp_r;
    logic            doWrite;
    logic            cmdWrite;
    logic            arTake;
    logic            rxCapture;
    logic            readDone;

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == REG_CMD) || (a == REG_STATUS) ||
                   (a == REG_RDATA) || (a == REG_RXCMD) ||
                   (a == REG_LCTRL);
    endfunction

    assign s_axi_awready = !awHeld_r && !bvalid_r;
    assign s_axi_wready  = !wHeld_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign doWrite  = awHeld_r && wHeld_r && !bvalid_r;
    // A command written while a read runs is dropped
    assign cmdWrite = doWrite && awAddr_r == REG_CMD && !busy_r;
    assign arTake   = s_axi_arvalid && !rvalid_r;
    assign readDone = (state_r == L_TURN);
    assign rxCapture = bus.dir && dirPrev_r && !bus.nxt && !readDone;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r  <= 1'b0;
            wData_r  <= 32'h00000000;
            wStrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reqAddr_r <= 8'h00;
            reqExt_r  <= 1'b0;
            stp_r     <= 1'b0;
        end else if (clkEn && doWrite) begin
            if (cmdWrite) begin
                reqAddr_r <= wData_r[7:0];
                reqExt_r  <= wData_r[CMD_EXT_BIT];
            end
            if (awAddr_r == REG_LCTRL && wStrb_r[0]) begin
                stp_r <= wData_r[LCTRL_STP_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= RESP_OKAY;
        end else if (clkEn) begin
            if (arTake) begin
                rvalid_r <= 1'b1;
                rresp_r  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                rdata_r  <= 32'h00000000;
                unique case (s_axi_araddr)
                    REG_CMD:    rdata_r <= {23'h0, reqExt_r, reqAddr_r};
                    REG_STATUS: rdata_r <= {29'h0, rxNew_r, done_r, busy_r};
                    REG_RDATA:  rdata_r <= {24'h0, rdByte_r};
                    REG_RXCMD:  rdata_r <= {24'h0, rxByte_r};
                    REG_LCTRL:  rdata_r <= {31'h0, stp_r};
                    default:    rdata_r <= 32'h00000000;
                endcase
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Status flags: the hardware set wins over the software clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            rdByte_r <= 8'h00;
            rxByte_r <= 8'h00;
            rxNew_r  <= 1'b0;
        end else if (clkEn) begin
            if (cmdWrite) begin
                busy_r <= 1'b1;
                done_r <= 1'b0;
            end
            if (readDone) begin
                busy_r   <= 1'b0;
                done_r   <= 1'b1;
                rdByte_r <= bus.busData;
            end
            if (rxCapture) begin
                rxByte_r <= bus.busData;
                rxNew_r  <= 1'b1;
            end else if (arTake && s_axi_araddr == REG_RXCMD) begin
                rxNew_r <= 1'b0;
            end
        end
    end

    // Bus side sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= L_IDLE;
            dataOut_r <= IDLE_CMD;
            oeN_r     <= 1'b0;
            dirPrev_r <= 1'b0;
        end else if (clkEn) begin
            dirPrev_r <= bus.dir;
            unique case (state_r)
                L_IDLE: begin
                    oeN_r     <= 1'b0;
                    dataOut_r <= IDLE_CMD;
                    if (busy_r && !bus.dir && !dirPrev_r) begin
                        state_r   <= L_CMD;
                        dataOut_r <= {CMD_READ, reqExt_r ? EXT_ADDR_CODE
                                                      : reqAddr_r[5:0]};
                    end
                end
                L_CMD: begin
                    if (bus.dir) begin
                        // Preempted by a status byte: retry later
                        state_r   <= L_IDLE;
                        dataOut_r <= IDLE_CMD;
                    end else if (bus.nxt) begin
                        state_r   <= reqExt_r ? L_EXT : L_WAIT;
                        dataOut_r <= reqExt_r ? reqAddr_r : IDLE_CMD;
                    end
                end
                L_EXT: begin
                    state_r   <= L_WAIT;
                    dataOut_r <= IDLE_CMD;
                end
                L_WAIT: begin
                    if (bus.dir) state_r <= L_TURN;
                end
                L_TURN: begin
                    // Sample edge; release for the turnaround after it
                    state_r <= L_GAP;
                    oeN_r   <= 1'b1;
                end
                L_GAP: begin
                    state_r <= L_IDLE;
                    oeN_r   <= 1'b0;                               // [R6]
                end
            endcase
        end
    end

    // Off while the transceiver owns the bus and for one cycle after
    assign bus.linkOeN     = oeN_r || bus.dir || dirPrev_r;
    assign bus.linkDataOut = dataOut_r;
    assign bus.stp         = stp_r;

endmodule // ulr_link_end

// *** shared/ulr_pkg.sv ***
// Shared constants for the ULPI register read and status byte link
package ulr_pkg;
    // Bus command byte
    localparam logic [1:0] CMD_READ      = 2'h3;
    localparam logic [5:0] EXT_ADDR_CODE = 6'h2F;
    localparam logic [7:0] IDLE_CMD      = 8'h00;

    // Status byte field positions
    localparam int LS_LSB  = 0;
    localparam int VB_LSB  = 2;
    localparam int RXE_LSB = 4;
    localparam int ID_BIT  = 6;
    localparam int ALT_BIT = 7;

    // Supply level codes
    localparam logic [1:0] VB_LOW   = 2'h0;
    localparam logic [1:0] VB_MID   = 2'h1;
    localparam logic [1:0] VB_SESS  = 2'h2;
    localparam logic [1:0] VB_VALID = 2'h3;

    // Receive event codes
    localparam logic [1:0] RXE_NONE = 2'h0;
    localparam logic [1:0] RXE_ACT  = 2'h1;
    localparam logic [1:0] RXE_ERR  = 2'h3;
    localparam logic [1:0] RXE_DISC = 2'h2;

    // Pin inputs of the transceiver end, in sync vector order
    localparam int PIN_DP   = 0;
    localparam int PIN_DM   = 1;
    localparam int PIN_SEND = 2;
    localparam int PIN_SVLD = 3;
    localparam int PIN_VVLD = 4;
    localparam int PIN_ID   = 5;
    localparam int PIN_N    = 6;

    // Cycles the transceiver holds the bus after reset
    localparam int STARTUP_CYCLES_DEF = 16;
    localparam int START_CNT_W        = 16;

    // Link controller registers, byte addresses
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RDATA  = 8'h08;
    localparam logic [7:0] REG_RXCMD  = 8'h0C;
    localparam logic [7:0] REG_LCTRL  = 8'h10;
    localparam int CMD_EXT_BIT  = 8;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_DONE_BIT  = 1;
    localparam int ST_RXNEW_BIT = 2;
    localparam int LCTRL_STP_BIT = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** shared/ulr_bus_if.sv ***
// Shared 8-bit data bus with direction, throttle and stop lines
`timescale 1ns/1ps
interface ulr_bus_if;
    import ulr_pkg::*;
    logic       dir;
    logic       nxt;
    logic       stp;
    logic [7:0] phyDataOut;
    logic       phyOeN;
    logic [7:0] linkDataOut;
    logic       linkOeN;
    logic [7:0] busData;

    // Undriven bus reads as idle
    assign busData = !phyOeN  ? phyDataOut  :
                     !linkOeN ? linkDataOut : IDLE_CMD;

    modport phy  (output dir, nxt, phyDataOut, phyOeN,
                  input  stp, busData);
    modport link (output stp, linkDataOut, linkOeN,
                  input  dir, nxt, busData);
endinterface

// *** hw/ulr_phy_end.sv ***
// Transceiver end: register read service and status byte sender
// Notes on behaviour
// [R1] Read command: top bits 11, address low six
// [R2] Raise throttle two cycles after command
// [R3] Next cycle: take bus, drop throttle
// [R4] After turnaround, drive addressed register value
// [R5] Link samples; direction drops same cycle (the code drops it in the cycle after the data cycle)
// [R6] Link drives idle after release turnaround
// [R7] Extended read: code 2Fh, then full address
// [R8] Extended: latch address, take bus, drive, release
// [R9] Status byte starts on idle bus, direction up
// [R10] Single or back to back status bytes
// [R11] Send on line, supply or ID change
// [R12] Send after start-up and mode exit
// [R13] Receiving: direction high, throttle low, status
// [R14] Hold status bytes while transmit runs
// [R15] Byte shows conditions at send time
// [R16] Bits 1:0 carry line state
// [R17] Bits 3:2 encode supply level
// [R18] Bits 5:4 encode receive events
// [R19] Bit 6 mirrors ID pin
// [R20] Bit 7 flags latched alternate interrupt
// [R21] Nobody drives, bus ignored on turnaround
// [R22] Line state from two single-ended receivers
`timescale 1ns/1ps
module ulr_phy_end
    import ulr_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
    // Clock and reset
    input  logic             sys_clk,
    input  logic             sys_rst,
    input  logic             clkEn,
    // Shared bus
    ulr_bus_if.phy           bus,
    // Register file access
    output logic [7:0]       regRdAddr,
    output logic             regRdEn,
    input  logic [7:0]       regRdData,
    // Pin level inputs: dp, dm, comparators, id
    input  logic [PIN_N-1:0] pinIn,
    // On-clock status from receive and transmit logic
    input  logic             rxActive,
    input  logic             rxError,
    input  logic             hostDisconnect,
    input  logic             altIntLatched,
    input  logic             txBusy,
    input  logic             lowPowerExit
);

    typedef enum logic [9:0] {
        P_START   = 10'h001,
        P_IDLE    = 10'h002,
        P_CMD     = 10'h004,
        P_NXT     = 10'h008,
        P_EXT     = 10'h010,
        P_RDTURN  = 10'h020,
        P_RDDRIVE = 10'h040,
        P_RXTURN  = 10'h080,
        P_RXSEND  = 10'h100,
        P_GAP     = 10'h200
    } ulr_phy_state_t;

    localparam logic [START_CNT_W-1:0] START_LOAD =
        START_CNT_W'(STARTUP_CYCLES - 1);

    ulr_phy_state_t         state_r;
    ulr_phy_state_t         state_nxt;
    logic [PIN_N-1:0]       pinMeta_r;
    logic [PIN_N-1:0]       pinSync_r;
    logic [START_CNT_W-1:0] startCnt_r;
    logic [7:0]             addr_r;
    logic                   extRead_r;
    logic [7:0]             dataOut_r;
    logic [7:0]             statusNow;
    logic [7:0]             prevStatus_r;
    logic                   pending_r;
    logic                   pending_nxt;
    logic                   statusEvent;
    logic                   startEvent;
    logic                   sendNow;
    logic                   busIdle;

    function automatic logic [1:0] encVbus(input logic session_end_indicator,
                                           input logic session_valid_indicator,
                                           input logic supplyVld);
        if (supplyVld) encVbus = VB_VALID;
        else if (session_valid_indicator) encVbus = VB_SESS;
        else if (session_end_indicator) encVbus = VB_LOW;
        else encVbus = VB_MID;
    endfunction

    function automatic logic [1:0] encRx(input logic act,
                                         input logic err,
                                         input logic disc);
        if (disc) encRx = RXE_DISC;
        else if (act && err) encRx = RXE_ERR;
        else if (act) encRx = RXE_ACT;
        else encRx = RXE_NONE;
    endfunction

    // Pins are asynchronous to sys_clk: two stages before use
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pinMeta_r[gi] <= 1'b0;
                    pinSync_r[gi] <= 1'b0;
                end else if (clkEn) begin
                    pinMeta_r[gi] <= pinIn[gi];
                    pinSync_r[gi] <= pinMeta_r[gi];
                end
            end
        end
    endgenerate

    // Status byte is built live, so it shows send-time state    [R15]
    always_comb begin
        statusNow = 8'h00;
        statusNow[LS_LSB +: 2] = {pinSync_r[PIN_DM],
                                  pinSync_r[PIN_DP]};              // [R16] [R22]
        statusNow[VB_LSB +: 2] = encVbus(pinSync_r[PIN_SEND],
                                         pinSync_r[PIN_SVLD],
                                         pinSync_r[PIN_VVLD]);     // [R17]
        statusNow[RXE_LSB +: 2] = encRx(rxActive, rxError,
                                        hostDisconnect);           // [R18]
        statusNow[ID_BIT]  = pinSync_r[PIN_ID];                    // [R19]
        statusNow[ALT_BIT] = altIntLatched;                        // [R20]
    end

    assign busIdle     = (bus.busData == IDLE_CMD) && !bus.stp;
    assign statusEvent = (statusNow != prevStatus_r);              // [R11]
    assign startEvent  = (state_r == P_START) && (startCnt_r == '0)
                         && !bus.stp;                              // [R12]
    assign sendNow     = (state_nxt == P_RXSEND);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            P_START: begin
                if (startCnt_r == '0) state_nxt = P_GAP;
            end
            P_IDLE: begin
                if (!bus.stp && bus.busData[7:6] == CMD_READ) begin
                    state_nxt = P_CMD;                             // [R1]
                end else if (busIdle && pending_r && !txBusy) begin
                    state_nxt = P_RXTURN;                          // [R9] [R14]
                end
            end
            P_CMD:     state_nxt = P_NXT;                          // [R2]
            P_NXT:     state_nxt = extRead_r ? P_EXT : P_RDTURN;   // [R3] [R7]
            P_EXT:     state_nxt = P_RDTURN;                       // [R8]
            P_RDTURN:  state_nxt = P_RDDRIVE;                      // [R4]
            P_RDDRIVE: state_nxt = P_GAP;                          // [R5]
            P_RXTURN:  state_nxt = P_RXSEND;
            P_RXSEND: begin
                // Stay on the bus while receiving or events queue up
                if (!txBusy && (pending_r || rxActive)) begin
                    state_nxt = P_RXSEND;                          // [R10] [R13]
                end else begin
                    state_nxt = P_GAP;
                end
            end
            P_GAP:     state_nxt = P_IDLE;                         // [R21]
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) state_r <= P_START;
        else if (clkEn) state_r <= state_nxt;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) startCnt_r <= START_LOAD;
        else if (clkEn && state_r == P_START && startCnt_r != '0) begin
            startCnt_r <= startCnt_r - 1'b1;
        end
    end

    // Address capture: six-bit field, or the extra byte for 2Fh
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_r    <= 8'h00;
            extRead_r <= 1'b0;
        end else if (clkEn) begin
            if (state_r == P_IDLE && state_nxt == P_CMD) begin
                addr_r    <= {2'b00, bus.busData[5:0]};            // [R1]
                extRead_r <= (bus.busData[5:0] == EXT_ADDR_CODE);  // [R7]
            end else if (state_r == P_EXT) begin
                addr_r <= bus.busData;                             // [R8]
            end
        end
    end

    // Any event arriving as a byte goes out is kept for the next one
    assign pending_nxt = statusEvent || startEvent || lowPowerExit
                         || (pending_r && !sendNow);               // [R14]

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_r    <= 1'b0;
            prevStatus_r <= 8'h00;
        end else if (clkEn) begin
            pending_r    <= pending_nxt;
            prevStatus_r <= statusNow;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) dataOut_r <= 8'h00;
        else if (clkEn) begin
            if (state_nxt == P_RDDRIVE) dataOut_r <= regRdData;    // [R4] [R8]
            else if (sendNow) dataOut_r <= statusNow;              // [R15]
        end
    end

    // Bus outputs; turnaround states drive nothing
    assign bus.dir = (state_r == P_START) || (state_r == P_RDTURN) ||
                     (state_r == P_RDDRIVE) || (state_r == P_RXTURN) ||
                     (state_r == P_RXSEND);                        // [R3] [R9]
    assign bus.nxt = (state_r == P_NXT) || (state_r == P_EXT);     // [R2] [R13]
    assign bus.phyOeN = !((state_r == P_RDDRIVE) ||
                          (state_r == P_RXSEND));                  // [R21]
    assign bus.phyDataOut = dataOut_r;

    assign regRdAddr = addr_r;
    assign regRdEn   = (state_r == P_RDTURN);

endmodule // ulr_phy_end

// *** bench/ulr_bus_checker.sv ***
// Protocol checker for the shared bus between both ends
`timescale 1ns/1ps
module ulr_bus_checker
    import ulr_pkg::*;
(
    // Clock and reset
    input logic       sys_clk,
    input logic       sys_rst,
    // Bus
    input logic       dir,
    input logic       nxt,
    input logic       stp,
    input logic [7:0] busData,
    input logic       phyOeN,
    input logic       linkOeN
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_CMD_NXT: assert property (
        !dir && !linkOeN && !stp && busData[7:6] == CMD_READ
        && $past(busData) == IDLE_CMD |-> ##2 (nxt && !dir))
        else $error("throttle late after read command");
    AST_HANDOFF: assert property ($rose(nxt) |=>
        (dir && !nxt) or (nxt && !dir ##1 dir && !nxt))
        else $error("bus not taken after throttle");
    AST_TURN_UP: assert property ($rose(dir) |-> phyOeN && linkOeN)
        else $error("bus driven in turnaround");
    AST_TURN_DOWN: assert property ($fell(dir) |-> phyOeN && linkOeN)
        else $error("bus driven in release turnaround");
    AST_DATA_AFTER_TURN: assert property ($rose(dir) |=> !phyOeN)
        else $error("no data after turnaround");
    AST_READ_RELEASE: assert property (
        dir && $fell(nxt) |=> !phyOeN ##1 !dir)
        else $error("read data not one cycle");
    AST_NXT_LOW_DIR: assert property (dir |-> !nxt)
        else $error("throttle high while owning bus");
    AST_PHY_QUIET: assert property (!dir |-> phyOeN)
        else $error("transceiver drives without direction");
    AST_IDLE_AFTER: assert property (
        $fell(dir) |=> !linkOeN && busData == IDLE_CMD)
        else $error("no idle after release");

    cover property ($rose(nxt) ##1 !nxt);
    cover property (nxt ##1 nxt);
    cover property (!phyOeN ##1 !phyOeN);
endmodule // ulr_bus_checker

// *** bench/ulpi_register_read_rxcmd_bench.sv ***
// Self-checking bench joining both ends over the shared bus
`timescale 1ns/1ps
module ulpi_register_read_rxcmd_bench
    import ulr_pkg::*;
;
    typedef struct {logic [31:0] d; logic [1:0] r; bit c;} ulr_exp_t;
    logic sys_clk = 0, sys_rst = 1, rxA = 0, rxE = 0, disc = 0, alt = 0;
    logic txB = 0, lpx = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, regRdEn;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, regRdAddr, regRdData, a;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, lastR;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [PIN_N-1:0] pinIn = 6'h19;
    int err_total = 0, comparisons = 0, cyc = 0, seed = 78140;
    ulr_exp_t expQ[$];

    ulr_bus_if bus ();
    // Short start-up keeps the run brief
    ulr_phy_end #(.STARTUP_CYCLES(2)) i_ulr_phy_end (.sys_clk, .sys_rst,
        .clkEn(1'b1), .bus(bus.phy), .regRdAddr, .regRdEn, .regRdData,
        .pinIn, .rxActive(rxA), .rxError(rxE), .hostDisconnect(disc),
        .altIntLatched(alt), .txBusy(txB), .lowPowerExit(lpx));
    ulr_link_end i_ulr_link_end (.sys_clk, .sys_rst, .clkEn(1'b1),
        .bus(bus.link), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ulr_bus_checker i_ulr_bus_checker (.sys_clk, .sys_rst, .dir(bus.dir),
        .nxt(bus.nxt), .stp(bus.stp), .busData(bus.busData),
        .phyOeN(bus.phyOeN), .linkOeN(bus.linkOeN));

    // Register file model: scrambled address, only while read is enabled
    assign regRdData = regRdEn ? (regRdAddr ^ 8'hA5) : 8'h00;

    initial forever #2 sys_clk = ~sys_clk;

    task automatic wrap_up();
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(logic [31:0] got, logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t got %h want %h", $time, got, want);
        end
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            wrap_up();
        end
    end

    // Monitor: every response pops the oldest expectation
    always @(posedge sys_clk) begin
        if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
        begin
            ulr_exp_t e;
            e = expQ.pop_front();
            if (e.c) cmp(s_axi_rvalid ? s_axi_rdata : 32'h0, e.d);
            cmp({30'h0, s_axi_rvalid ? s_axi_rresp : s_axi_bresp},
                {30'h0, e.r});
        end
    end

    task automatic wr(logic [7:0] ad, logic [31:0] d, logic [1:0] r);
        @(posedge sys_clk);
        expQ.push_back('{32'h0, r, 1'b0});
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask

    task automatic rd(logic [7:0] ad, logic [31:0] d, logic [1:0] r, bit c);
        @(posedge sys_clk);
        expQ.push_back('{d, r, c});
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        lastR = s_axi_rdata;
        s_axi_rready <= 0;
    endtask

    task automatic waitBit(int b);
        int n = 0;
        do begin
            rd(REG_STATUS, 32'h0, RESP_OKAY, 0);
            n++;
        end while (!lastR[b] && n < 100);
        cmp({31'h0, lastR[b]}, 32'h1);
    endtask

    task automatic regRead(logic [7:0] ad, logic ext);
        wr(REG_CMD, {23'h0, ext, ad}, RESP_OKAY);
        waitBit(ST_DONE_BIT);
        rd(REG_RDATA, {24'h0, ad ^ 8'hA5}, RESP_OKAY, 1);
    endtask

    // Status byte as it should read for the present inputs
    function automatic logic [7:0] rxByte();
        logic [1:0] vb, ev;
        vb = pinIn[PIN_VVLD] ? 2'h3 : pinIn[PIN_SVLD] ? 2'h2 :
             pinIn[PIN_SEND] ? 2'h0 : 2'h1;
        ev = disc ? 2'h2 : (rxA && rxE) ? 2'h3 : rxA ? 2'h1 : 2'h0;
        return {alt, pinIn[PIN_ID], ev, vb, pinIn[PIN_DM], pinIn[PIN_DP]};
    endfunction

    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 0;
        for (int i = 0; i < 4; i++) begin
            a = 8'($random(seed)) & 8'h3F;
            if (a == 8'h2F) a = 8'h00;
            regRead(a, 1'b0);
            regRead(8'($random(seed)), 1'b1);
        end
        rd(8'h20, 32'h0, RESP_SLVERR, 1);
        wr(8'h24, 32'h1, RESP_SLVERR);
        // Pins change together with events, so several bytes may follow
        for (int i = 0; i < 10; i++) begin
            rd(REG_RXCMD, 32'h0, RESP_OKAY, 0);
            pinIn <= PIN_N'($random(seed));
            {rxA, rxE, disc} <= 3'($random(seed));
            // Flipping alt guarantees a new byte each pass
            alt <= !alt;
            waitBit(ST_RXNEW_BIT);
            repeat (12) @(posedge sys_clk);
            rd(REG_RXCMD, {24'h0, rxByte()}, RESP_OKAY, 1);
        end
        // Event during transmit is held back until transmit ends
        {rxA, txB} <= 2'h1;
        alt <= !alt;
        repeat (8) @(posedge sys_clk);
        rd(REG_RXCMD, 32'h0, RESP_OKAY, 0);
        repeat (8) @(posedge sys_clk);
        rd(REG_STATUS, 32'h2, RESP_OKAY, 1);
        txB <= 0;
        repeat (12) @(posedge sys_clk);
        rd(REG_RXCMD, {24'h0, rxByte()}, RESP_OKAY, 1);
        lpx <= 1;
        @(posedge sys_clk);
        lpx <= 0;
        repeat (12) @(posedge sys_clk);
        rd(REG_STATUS, 32'h6, RESP_OKAY, 1);
        repeat (4) @(posedge sys_clk);
        wrap_up();
    end
endmodule // ulpi_register_read_rxcmd_bench
